// File: core/pmc_pkg.sv
package pmc_pkg;

    // ----------------------------------------------------------------
    // Serial frame layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [4:0] CMD_BITS = 5'd16;
    localparam logic [4:0] FRAME_BITS = 5'd24;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [14:0] OFS_CFG_B = 15'h029a;
    localparam logic [14:0] OFS_CFG_C = 15'h029b;
    localparam logic [14:0] OFS_CFG_D = 15'h029c;
    localparam logic [14:0] OFS_ALARM = 15'h02c0;

    // ----------------------------------------------------------------
    // Reset values and mode encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CFG_B = 8'h0f;
    localparam logic [7:0] RST_CFG_C = 8'h04;
    localparam logic [7:0] RST_CFG_D = 8'h1b;
    localparam logic [7:0] RST_ALARM = 8'h00;
    localparam logic [7:0] LP_CFG_B = 8'h06;
    localparam logic [7:0] HP_CFG_B = 8'h0f;
    localparam logic [7:0] LP_CFG_C = 8'h00;
    localparam logic [7:0] HP_CFG_C = 8'h04;
    localparam logic [7:0] LP_CFG_D = 8'h14;
    localparam logic [7:0] HP_CFG_D = 8'h1b;

    // Position of the summary bit in the alarm summary register.
    localparam int ALARM_BIT = 0;

    // Operating mode seen by the converter core.
    typedef enum logic [1:0] {MODE_HIGH_PERF, MODE_LOW_POWER, MODE_MIXED} op_mode_t;

endpackage : pmc_pkg

// File: core/serial_cfg_port.sv
`timescale 1ns/100ps
module serial_cfg_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic sen_n,
    input wire logic sdi,
    input wire logic [7:0] rd_data,
    output logic [14:0] addr_q,
    output logic wr_stb_q,
    output logic [7:0] wr_data_q,
    output logic sdo_q,
    output logic sdo_oe_q
);

    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} frame_state_t;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] meta_q, sync_q;
    logic sclk_prev_q;
    frame_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic [23:0] shift_q, shift_d;
    logic rd_q, rd_d;
    logic [14:0] addr_d;
    logic wr_stb_d;
    logic [7:0] wr_data_d, out_q, out_d;
    logic sdo_d, sdo_oe_d;
    logic rise, fall;

    // Pins come from the host's clock, so each passes two flip-flops.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // Reset to the pins' idle levels (clock low, enable high) so no false edge follows reset.
            meta_q <= 3'h2;
            sync_q <= 3'h2;
            sclk_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            meta_q <= {sclk, sen_n, sdi};
            sync_q <= meta_q;
            sclk_prev_q <= sync_q[2];
        end
    end

    assign rise = sync_q[2] & ~sclk_prev_q;
    assign fall = ~sync_q[2] & sclk_prev_q;

    // ----------------------------------------------------------------
    // Frame engine: read/write bit, 15 address bits, 8 data bits
    // ----------------------------------------------------------------
    // Input is sampled on sclk rising; read data changes on sclk falling.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        rd_d = rd_q;
        addr_d = addr_q;
        wr_stb_d = 1'b0;
        wr_data_d = wr_data_q;
        out_d = out_q;
        sdo_d = sdo_q;
        sdo_oe_d = sdo_oe_q;
        if (sync_q[1])
        begin
            state_d = ST_IDLE;
            cnt_d = 5'd0;
            sdo_oe_d = 1'b0;
        end
        else
        begin
            if (state_q == ST_IDLE)
                state_d = ST_CMD;
            if (rise && cnt_q < pmc_pkg::FRAME_BITS)
            begin
                shift_d = {shift_q[22:0], sync_q[0]};
                cnt_d = cnt_q + 5'd1;
                if (cnt_q == pmc_pkg::CMD_BITS - 5'd1)
                begin
                    rd_d = shift_q[14];
                    addr_d = {shift_q[13:0], sync_q[0]};
                    state_d = ST_DATA;
                end
                if (cnt_q == pmc_pkg::FRAME_BITS - 5'd1 && !rd_q)
                begin
                    wr_stb_d = 1'b1;
                    wr_data_d = {shift_q[6:0], sync_q[0]};
                end
            end
            if (fall && state_q == ST_DATA && rd_q)
            begin
                if (cnt_q == pmc_pkg::CMD_BITS)
                begin
                    sdo_d = rd_data[7];
                    out_d = {rd_data[6:0], 1'b0};
                    sdo_oe_d = 1'b1;
                end
                else
                begin
                    sdo_d = out_q[7];
                    out_d = {out_q[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 5'd0;
            shift_q <= 24'h000000;
            rd_q <= 1'b0;
            addr_q <= 15'h0000;
            wr_stb_q <= 1'b0;
            wr_data_q <= 8'h00;
            out_q <= 8'h00;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
            wr_stb_q <= wr_stb_d;
            wr_data_q <= wr_data_d;
            out_q <= out_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
        end
    end

endmodule : serial_cfg_port

// File: core/power_mode_config_regs.sv
// Summary of operation
// RULE1: third register: 0x00 low power, 0x04 performance.
// RULE2: fourth register: 0x14 low power, 0x1b performance.
// RULE3: host writes all mode registers as group.
// RULE4: host calibrates after any mode change.
// RULE5: host clears calibration and link enables first.
// RULE6: host writes only the two defined encodings.
// RULE7: third register 8-bit RW, 0x29b, reset 0x04.
// RULE8: fourth register 8-bit RW, 0x29c, reset 0x1b.
// RULE9: alarm summary read-only at 0x2c0, reset zero.
// RULE10: second register: 0x06 low power, 0x0f performance.
// RULE11: summary bit 0 set by unmasked active alarm.
// RULE12: alarm summary ignores writes, upper bits zero.
`timescale 1ns/100ps
module power_mode_config_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic sen_n,
    input wire logic sdi,
    input wire logic [7:0] alarm_flags,
    input wire logic [7:0] alarm_flag_mask,
    output logic sdo,
    output logic sdo_oe,
    output logic [7:0] power_mode_field_b_q,
    output logic [7:0] power_mode_field_c_q,
    output logic [7:0] power_mode_field_d_q,
    output pmc_pkg::op_mode_t op_mode_q,
    output logic reserved_code_q,
    output logic alarm_out_q
);

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    logic [14:0] addr;
    logic wr_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    serial_cfg_port u_port (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .sclk(sclk),
        .sen_n(sen_n),
        .sdi(sdi),
        .rd_data(rd_data),
        .addr_q(addr),
        .wr_stb_q(wr_stb),
        .wr_data_q(wr_data),
        .sdo_q(sdo),
        .sdo_oe_q(sdo_oe)
    );

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // A register write hits only when the frame's address matches.
    function automatic logic hit(input logic [14:0] a, input logic [14:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Mixed settings are reported rather than guessed, since the core
    // is only characterised with the whole group in one mode.
    function automatic pmc_pkg::op_mode_t decode_mode(input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
        if (b == pmc_pkg::LP_CFG_B && c == pmc_pkg::LP_CFG_C && d == pmc_pkg::LP_CFG_D)
            decode_mode = pmc_pkg::MODE_LOW_POWER;
        else if (b == pmc_pkg::HP_CFG_B && c == pmc_pkg::HP_CFG_C && d == pmc_pkg::HP_CFG_D)
            decode_mode = pmc_pkg::MODE_HIGH_PERF;
        else
            decode_mode = pmc_pkg::MODE_MIXED;
    endfunction : decode_mode

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    logic [7:0] cfg_b_d, cfg_c_d, cfg_d_d, alarm_q, alarm_d;
    pmc_pkg::op_mode_t op_mode_d;
    logic reserved_code_d;
    logic alarm_hit;

    assign alarm_hit = |(alarm_flags & ~alarm_flag_mask);

    // Next values of the mode group and the alarm summary.
    always_comb
    begin
        cfg_b_d = power_mode_field_b_q;
        cfg_c_d = power_mode_field_c_q;
        cfg_d_d = power_mode_field_d_q;
        if (wr_stb && hit(addr, pmc_pkg::OFS_CFG_B))
            cfg_b_d = wr_data; // RULE10
        if (wr_stb && hit(addr, pmc_pkg::OFS_CFG_C))
            cfg_c_d = wr_data; // RULE7
        if (wr_stb && hit(addr, pmc_pkg::OFS_CFG_D))
            cfg_d_d = wr_data; // RULE8
        // The summary has no write path at all; upper bits stay zero.
        alarm_d = pmc_pkg::RST_ALARM; // RULE12
        alarm_d[pmc_pkg::ALARM_BIT] = alarm_hit; // RULE11
        // Decoding uses the values being stored, so the mode changes on the same edge as the written register.
        op_mode_d = decode_mode(cfg_b_d, cfg_c_d, cfg_d_d); // RULE1 RULE2 RULE10
        // Nothing stops the host writing a reserved code; it is only flagged.
        reserved_code_d = !((cfg_b_d == pmc_pkg::LP_CFG_B || cfg_b_d == pmc_pkg::HP_CFG_B)
                         && (cfg_c_d == pmc_pkg::LP_CFG_C || cfg_c_d == pmc_pkg::HP_CFG_C)
                         && (cfg_d_d == pmc_pkg::LP_CFG_D || cfg_d_d == pmc_pkg::HP_CFG_D));
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_mode_field_b_q <= pmc_pkg::RST_CFG_B; // RULE10
            power_mode_field_c_q <= pmc_pkg::RST_CFG_C; // RULE7
            power_mode_field_d_q <= pmc_pkg::RST_CFG_D; // RULE8
            alarm_q <= pmc_pkg::RST_ALARM; // RULE9
            op_mode_q <= pmc_pkg::MODE_HIGH_PERF;
            reserved_code_q <= 1'b0;
            alarm_out_q <= 1'b0;
        end
        else if (ce)
        begin
            power_mode_field_b_q <= cfg_b_d;
            power_mode_field_c_q <= cfg_c_d;
            power_mode_field_d_q <= cfg_d_d;
            alarm_q <= alarm_d;
            op_mode_q <= op_mode_d;
            reserved_code_q <= reserved_code_d;
            alarm_out_q <= alarm_d[pmc_pkg::ALARM_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Read-back
    // ----------------------------------------------------------------
    // Unmapped addresses read as zero.
    always_comb
    begin
        rd_data = 8'h00;
        if (hit(addr, pmc_pkg::OFS_CFG_B))
            rd_data = power_mode_field_b_q;
        if (hit(addr, pmc_pkg::OFS_CFG_C))
            rd_data = power_mode_field_c_q;
        if (hit(addr, pmc_pkg::OFS_CFG_D))
            rd_data = power_mode_field_d_q;
        if (hit(addr, pmc_pkg::OFS_ALARM))
            rd_data = alarm_q; // RULE9
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_low_power_decode: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        ce && power_mode_field_b_q == pmc_pkg::LP_CFG_B && power_mode_field_c_q == pmc_pkg::LP_CFG_C
        && power_mode_field_d_q == pmc_pkg::LP_CFG_D && !wr_stb |=> op_mode_q == pmc_pkg::MODE_LOW_POWER)
        else $error("Low power group not decoded as low power.");

    a_high_perf_decode: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        ce && power_mode_field_b_q == pmc_pkg::HP_CFG_B && power_mode_field_c_q == pmc_pkg::HP_CFG_C
        && power_mode_field_d_q == pmc_pkg::HP_CFG_D && !wr_stb |=> op_mode_q == pmc_pkg::MODE_HIGH_PERF)
        else $error("Performance group not decoded as performance.");

    a_cfg_b_reserved: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        ce && !wr_stb && power_mode_field_b_q != pmc_pkg::LP_CFG_B && power_mode_field_b_q != pmc_pkg::HP_CFG_B
        |=> reserved_code_q && op_mode_q == pmc_pkg::MODE_MIXED)
        else $error("Reserved second register code not flagged.");

    a_cfg_c_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        ce && wr_stb && addr == pmc_pkg::OFS_CFG_C
        |=> power_mode_field_c_q == $past(wr_data) && rd_data == $past(wr_data))
        else $error("Third register write not stored.");

    a_cfg_d_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
        ce && wr_stb && addr == pmc_pkg::OFS_CFG_D
        |=> power_mode_field_d_q == $past(wr_data) && rd_data == $past(wr_data))
        else $error("Fourth register write not stored.");

    a_alarm_readback: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
        addr == pmc_pkg::OFS_ALARM |-> rd_data == {7'h00, alarm_out_q})
        else $error("Alarm summary read-back differs from summary bit.");

    a_alarm_summary: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
        ce |=> alarm_out_q == $past(alarm_hit))
        else $error("Alarm summary does not follow unmasked alarms.");

    a_alarm_upper_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
        ce && wr_stb && addr == pmc_pkg::OFS_ALARM |=> alarm_q[7:1] == 7'h00 ##1 alarm_q[7:1] == 7'h00)
        else $error("Alarm summary upper bits changed by a write.");

    // Reset leaves the whole group in the performance codes.
    a_reset_defaults: assert property (@(posedge clk) disable iff (sys_rst) // RULE7 RULE8
        $past(sys_rst) |-> power_mode_field_b_q == pmc_pkg::RST_CFG_B
        && power_mode_field_c_q == pmc_pkg::RST_CFG_C && power_mode_field_d_q == pmc_pkg::RST_CFG_D
        && op_mode_q == pmc_pkg::MODE_HIGH_PERF && !reserved_code_q)
        else $error("Mode group not at its reset codes after reset.");

    // The second register takes a write one edge after the strobe, like the others.
    a_cfg_b_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        ce && wr_stb && addr == pmc_pkg::OFS_CFG_B
        |=> power_mode_field_b_q == $past(wr_data) && rd_data == $past(wr_data))
        else $error("Second register write not stored.");

    // A reserved third register code must never pass as a coherent mode.
    a_cfg_c_reserved: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        ce && !wr_stb && power_mode_field_c_q != pmc_pkg::LP_CFG_C && power_mode_field_c_q != pmc_pkg::HP_CFG_C
        |=> reserved_code_q && op_mode_q == pmc_pkg::MODE_MIXED)
        else $error("Reserved third register code not flagged.");

    // A reserved fourth register code must never pass as a coherent mode.
    a_cfg_d_reserved: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        ce && !wr_stb && power_mode_field_d_q != pmc_pkg::LP_CFG_D && power_mode_field_d_q != pmc_pkg::HP_CFG_D
        |=> reserved_code_q && op_mode_q == pmc_pkg::MODE_MIXED)
        else $error("Reserved fourth register code not flagged.");

    // Only defined codes in all three registers clear the reserved flag.
    a_defined_codes_clean: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        ce && !wr_stb && (power_mode_field_b_q == pmc_pkg::LP_CFG_B || power_mode_field_b_q == pmc_pkg::HP_CFG_B)
        && (power_mode_field_c_q == pmc_pkg::LP_CFG_C || power_mode_field_c_q == pmc_pkg::HP_CFG_C)
        && (power_mode_field_d_q == pmc_pkg::LP_CFG_D || power_mode_field_d_q == pmc_pkg::HP_CFG_D)
        |=> !reserved_code_q)
        else $error("Defined mode codes flagged as reserved.");

    // Without a write strobe the mode group keeps its contents.
    a_mode_group_hold: assert property (@(posedge clk) disable iff (sys_rst) // RULE7 RULE8
        ce && !wr_stb |=> $stable(power_mode_field_b_q) && $stable(power_mode_field_c_q)
        && $stable(power_mode_field_d_q))
        else $error("Mode register changed without a write.");

    // Clock enable low freezes the third and fourth registers, the mode and the summary bit alike.
    a_frozen_while_off: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
        !ce |=> $stable(power_mode_field_c_q) && $stable(power_mode_field_d_q) && $stable(op_mode_q)
        && $stable(alarm_out_q))
        else $error("State moved while clock enable was low.");

    // A write aimed at the summary register must not spill into the mode group.
    a_alarm_write_ignored: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
        ce && wr_stb && addr == pmc_pkg::OFS_ALARM |=> $stable(power_mode_field_b_q)
        && $stable(power_mode_field_c_q) && $stable(power_mode_field_d_q))
        else $error("Alarm summary write changed a mode register.");

endmodule : power_mode_config_regs

// File: sim/serial_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host side of the serial configuration port
// ----------------------------------------------------------------
module serial_host_model #(
    parameter int HALF = 5
) (
    input wire logic clk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sclk,
    output logic sen_n,
    output logic sdi
);
    // The serial clock stands low between frames, as a real host would leave it.
    initial
    begin
        sclk = 1'b0;
        sen_n = 1'b1;
        sdi = 1'b0;
    end

    // One whole frame: read flag, 15-bit address, 8 data bits, all MSB first.
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic oe_ok);
        logic [23:0] word;
        word = {rd, addr, wdata};
        rdata = 8'h00;
        oe_ok = 1'b1;
        @(negedge clk);
        sen_n = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            sdi = word[23 - i];
            repeat (HALF) @(negedge clk);
            // Data bits are sampled late in the low phase, long after the port has shifted them out.
            if (i >= 16)
            begin
                rdata = {rdata[6:0], sdo};
                oe_ok = oe_ok & (sdo_oe === rd);
            end
            sclk = 1'b1;
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        sen_n = 1'b1;
        sdi = ~sdi; // A released line must not keep showing the last bit.
        repeat (HALF) @(negedge clk);
    endtask : xfer
endmodule : serial_host_model

// File: sim/power_mode_config_regs_test.sv
`timescale 1ns/100ps
module power_mode_config_regs_test;
    logic clk, sys_rst, ce, sclk, sen_n, sdi, sdo, sdo_oe, reserved_code_q, alarm_out_q, oe_ok;
    logic [7:0] alarm_flags, alarm_flag_mask, fb, fc, fd, rdata, eb, ec, ed, v;
    logic [31:0] r;
    pmc_pkg::op_mode_t op_mode_q;
    int failures, num_checks, seed, sel;

    // ----------------------------------------------------------------
    // Design, host model and clock
    // ----------------------------------------------------------------
    power_mode_config_regs DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sclk(sclk), .sen_n(sen_n),
        .sdi(sdi), .alarm_flags(alarm_flags), .alarm_flag_mask(alarm_flag_mask), .sdo(sdo),
        .sdo_oe(sdo_oe), .power_mode_field_b_q(fb), .power_mode_field_c_q(fc),
        .power_mode_field_d_q(fd), .op_mode_q(op_mode_q), .reserved_code_q(reserved_code_q),
        .alarm_out_q(alarm_out_q));
    serial_host_model host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .sen_n(sen_n), .sdi(sdi));

    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Expectations and comparisons
    // ----------------------------------------------------------------
    // A group counts as one mode only when every register holds that mode's code.
    function automatic pmc_pkg::op_mode_t exp_mode(input logic [7:0] b, c, d);
        if (b == 8'h0f && c == 8'h04 && d == 8'h1b)
            return pmc_pkg::MODE_HIGH_PERF;
        if (b == 8'h06 && c == 8'h00 && d == 8'h14)
            return pmc_pkg::MODE_LOW_POWER;
        return pmc_pkg::MODE_MIXED;
    endfunction : exp_mode

    function automatic logic exp_resv(input logic [7:0] b, c, d);
        return !(b inside {8'h06, 8'h0f}) || !(c inside {8'h00, 8'h04}) || !(d inside {8'h14, 8'h1b});
    endfunction : exp_resv

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic check_mode(input pmc_pkg::op_mode_t got, input pmc_pkg::op_mode_t exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t operating mode: got %0d expected %0d", $time, got, exp);
        end
    endtask : check_mode

    // Writes keep a shadow copy of the three mode registers for later comparison.
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rdata, oe_ok);
        check_val({7'h00, oe_ok}, 8'h01, "output enable in write frame");
        case (a)
            15'h029a: eb = d;
            15'h029b: ec = d;
            15'h029c: ed = d;
            default: ;
        endcase
    endtask : wr

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 8'h00, rdata, oe_ok);
        check_val({7'h00, oe_ok}, 8'h01, "output enable in read frame");
        check_val(rdata, exp, "read data");
    endtask : rd_chk

    task automatic chk_state();
        check_val(fb, eb, "second mode field");
        check_val(fc, ec, "third mode field");
        check_val(fd, ed, "fourth mode field");
        check_mode(op_mode_q, exp_mode(eb, ec, ed));
        check_val({7'h00, reserved_code_q}, {7'h00, exp_resv(eb, ec, ed)}, "reserved flag");
    endtask : chk_state

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    // Inputs change on the falling edge so the rising edge always samples settled values.
    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        ce = 1'b1;
        alarm_flags = 8'h00;
        alarm_flag_mask = 8'h00;
        seed = 32'h6199dc05;
        {eb, ec, ed} = {8'h0f, 8'h04, 8'h1b};
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        chk_state();
        rd_chk(15'h029b, 8'h04);
        rd_chk(15'h029c, 8'h1b);
        rd_chk(15'h029a, 8'h0f);
        rd_chk(15'h02c0, 8'h00);
        $display("test reset values done");
        // Whole-group switches to low power and back; every partial step must read as mixed.
        for (int m = 0; m < 2; m++)
        begin
            wr(15'h029a, m ? 8'h0f : 8'h06);
            chk_state();
            wr(15'h029b, m ? 8'h04 : 8'h00);
            chk_state();
            wr(15'h029c, m ? 8'h1b : 8'h14);
            chk_state();
        end
        $display("test group switch done");
        // Random codes, defined and reserved, into random mode registers.
        repeat (12)
        begin
            r = $random(seed);
            sel = (r[9:8] == 2'd3) ? 2 : int'(r[9:8]);
            v = r[7:0];
            wr(15'h029a + 15'(sel), v);
            chk_state();
            rd_chk(15'h029a + 15'(sel), v);
        end
        $display("test random codes done");
        // A reset in mid-run must bring back the performance group whatever was written before.
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        {eb, ec, ed} = {8'h0f, 8'h04, 8'h1b};
        @(negedge clk);
        chk_state();
        rd_chk(15'h029c, 8'h1b);
        $display("test mid-run reset done");
        // Alarm summary: corner pairs first, then random flags and masks.
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            @(negedge clk);
            alarm_flags = (k == 0) ? 8'hff : (k == 1) ? 8'h01 : r[7:0];
            alarm_flag_mask = (k == 0) ? 8'hff : (k == 1) ? 8'hfe : r[15:8];
            repeat (2) @(negedge clk);
            check_val({7'h00, alarm_out_q}, {7'h00, |(alarm_flags & ~alarm_flag_mask)}, "alarm bit");
            wr(15'h02c0, 8'hff);
            rd_chk(15'h02c0, {7'h00, |(alarm_flags & ~alarm_flag_mask)});
        end
        // Clock enable low must freeze the summary bit even while the alarm inputs move.
        alarm_flags = 8'h00;
        alarm_flag_mask = 8'h00;
        repeat (2) @(negedge clk);
        ce = 1'b0;
        alarm_flags = 8'h01;
        repeat (3) @(negedge clk);
        check_val({7'h00, alarm_out_q}, 8'h00, "alarm bit with clock enable low");
        ce = 1'b1;
        repeat (2) @(negedge clk);
        check_val({7'h00, alarm_out_q}, 8'h01, "alarm bit after clock enable");
        alarm_flags = 8'h00;
        $display("test alarm summary done");
        wr(15'h029d, 8'h55);
        rd_chk(15'h029d, 8'h00);
        chk_state();
        $display("test unmapped address done");
        print_verdict();
    end

    // A hung frame ends the run with a mismatch; the tests need about 13,300 cycles, so 30,000 is ample.
    initial
    begin
        #300000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : power_mode_config_regs_test
